// file: hw/pmc_core.sv
// Eight output macrocells with registered, complex and simple architecture.
// Assumes product terms come from an AND-array on the same mclk; pins sync here.
`timescale 1ns/1ps
`include "pmc_map.svh"
module pmc_core
  import pmc_pkg::*;
#(
  parameter int CELLS = `PMC_CELLS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [15:0] cfg_rdata,
  input wire logic [`PMC_TERMS-1:0] pterm [CELLS],
  input wire logic clk_pin,
  input wire logic oe_n_pin,
  input wire logic [CELLS-1:0] io_in,
  output pmc_pins_type io_pins,
  output logic [CELLS-1:0] fb_array,
  output logic clk_array,
  output logic oe_array
);

  pmc_mode_type mode_q;
  logic [2*CELLS-1:0] cell_cfg_q;
  logic [CELLS-1:0] reg_q;
  logic [1:0] clk_s_q;
  logic [1:0] oe_s_q;
  logic [CELLS-1:0] io_s1_q;
  logic [CELLS-1:0] io_s2_q;
  logic clk_last_q;
  logic clk_rise;
  logic [CELLS-1:0] sum8;
  logic [CELLS-1:0] sum7;
  logic [CELLS-1:0] term_oe;
  logic [CELLS-1:0] out_d;
  logic [CELLS-1:0] oe_d;
  logic [CELLS-1:0] fb_d;

  // Pin synchronisers; first stage is read only by the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      clk_s_q <= 2'h0;
      oe_s_q <= 2'h3;
      io_s1_q <= '0;
      io_s2_q <= '0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[0], clk_pin};
      oe_s_q <= {oe_s_q[0], oe_n_pin};
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      clk_last_q <= 1'b0;
    else
      clk_last_q <= clk_s_q[1];
  end

  assign clk_rise = clk_s_q[1] & ~clk_last_q;

  // Configuration writes; meant to be set once before use
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= PMC_MODE_REGISTERED;
      cell_cfg_q <= '1;
    end
    else if (cfg_wr)
    begin
      if (cfg_addr == `PMC_CFG_ADDR_MODE)
        mode_q <= pmc_mode_type'(cfg_wdata[1:0]);
      if (cfg_addr == `PMC_CFG_ADDR_CELL)
        cell_cfg_q <= cfg_wdata[2*CELLS-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cfg_rdata <= 16'h0000;
    else if (cfg_rd)
    begin
      case (cfg_addr)
        `PMC_CFG_ADDR_MODE: cfg_rdata <= {14'h0000, mode_q};
        `PMC_CFG_ADDR_CELL: cfg_rdata <= cell_cfg_q;
        `PMC_CFG_ADDR_STAT: cfg_rdata <= {8'h00, reg_q};
        `PMC_CFG_ADDR_PINS: cfg_rdata <= {io_pins.oe, io_pins.out};
        default: cfg_rdata <= 16'h0000;
      endcase
    end
  end

  // Sum terms: all eight, or seven with term 7 reserved as enable
  always_comb
  begin
    for (int i = 0; i < CELLS; i++)
    begin
      sum8[i] = |pterm[i];
      sum7[i] = |pterm[i][`PMC_SUM_OE-1:0];
      term_oe[i] = pterm[i][`PMC_SUM_OE];
    end
  end

  // Registers capture on a rising clock pin edge, in registered mode only
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_q <= `PMC_REG_RESET;
    else if (mode_q == PMC_MODE_REGISTERED && clk_rise)
      reg_q <= sum8;
  end

  always_comb
  begin
    out_d = '0;
    oe_d = '0;
    fb_d = '0;
    for (int i = 0; i < CELLS; i++)
    begin
      case (mode_q)
        PMC_MODE_REGISTERED:
        begin
          case (pmc_cell_type'(cell_cfg_q[2*i +: 2]))
            PMC_CELL_REG:
            begin
              out_d[i] = ~reg_q[i];
              oe_d[i] = ~oe_s_q[1];
              fb_d[i] = reg_q[i];
            end
            PMC_CELL_COMB:
            begin
              out_d[i] = sum7[i];
              oe_d[i] = term_oe[i];
              fb_d[i] = io_s2_q[i];
            end
            default:
            begin
              oe_d[i] = 1'b0;
              fb_d[i] = io_s2_q[i];
            end
          endcase
        end
        PMC_MODE_COMPLEX:
        begin
          out_d[i] = sum7[i];
          oe_d[i] = term_oe[i];
          if (i == `PMC_OUTER_HI)
            fb_d[i] = clk_s_q[1];
          else if (i == `PMC_OUTER_LO)
            fb_d[i] = oe_s_q[1];
          else
            fb_d[i] = io_s2_q[i];
        end
        default:
        begin
          if (i == `PMC_CENTRE_HI || i == `PMC_CENTRE_LO)
          begin
            out_d[i] = sum8[i];
            oe_d[i] = 1'b1;
          end
          else if (pmc_cell_type'(cell_cfg_q[2*i +: 2]) == PMC_CELL_IN)
            oe_d[i] = 1'b0;
          else
          begin
            out_d[i] = sum8[i];
            oe_d[i] = 1'b1;
          end
          // Centre cells have no pin of their own to read; neighbours borrow
          if (i == `PMC_CENTRE_HI || i == `PMC_CENTRE_LO)
            fb_d[i] = 1'b0;
          else if (i < `PMC_CENTRE_LO)
            fb_d[i] = io_s2_q[i+1];
          else
            fb_d[i] = io_s2_q[i-1];
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      io_pins <= '0;
      fb_array <= '0;
      clk_array <= 1'b0;
      oe_array <= 1'b0;
    end
    else
    begin
      io_pins.out <= out_d;
      io_pins.oe <= oe_d;
      fb_array <= fb_d;
      // Pins act as array inputs only outside registered mode
      clk_array <= (mode_q == PMC_MODE_REGISTERED) ? 1'b0 : clk_s_q[1];
      oe_array <= (mode_q == PMC_MODE_REGISTERED) ? 1'b0 : oe_s_q[1];
    end
  end

  input_cell_off_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_REGISTERED && cell_cfg_q[1:0] == `PMC_CFG_IN)
      |=> !io_pins.oe[0])
    else $error("input cell driver enabled");
  reg_reset_low_a: assert property (@(posedge mclk) $fell(rst) |-> reg_q == '0)
    else $error("register not low after reset");
  reg_inverse_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_REGISTERED && cell_cfg_q[3:2] == `PMC_CFG_REG && $stable(mode_q)
      && $stable(cell_cfg_q))
      |=> io_pins.out[1] == ~$past(reg_q[1]))
    else $error("registered pin not inverted");
  reg_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !clk_rise |=> $stable(reg_q))
    else $error("register changed without clock edge");
  reg_oe_pin_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_REGISTERED && cell_cfg_q[5:4] == `PMC_CFG_REG)
      |=> io_pins.oe[2] == ~$past(oe_s_q[1]))
    else $error("registered enable not from oe pin");
  fixed_pins_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_REGISTERED |=> !clk_array && !oe_array)
    else $error("clock pin reached array");
  centre_on_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_SIMPLE |=> io_pins.oe[`PMC_CENTRE_HI] && io_pins.oe[`PMC_CENTRE_LO]
      && !fb_array[`PMC_CENTRE_HI])
    else $error("centre cell not enabled");
  outer_fb_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_COMPLEX |=> fb_array[`PMC_OUTER_HI] == $past(clk_s_q[1]))
    else $error("outer feedback not clock pin");
  adjacent_fb_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_SIMPLE |=> fb_array[0] == $past(io_s2_q[1]))
    else $error("feedback not from adjacent pin");
  complex_oe_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_COMPLEX |=> io_pins.oe[5] == $past(pterm[5][`PMC_SUM_OE]))
    else $error("enable term not used");

  // Register path in steps: pin edge, load, then the inverted pin
  sequence pin_edge_s;
    mode_q == PMC_MODE_REGISTERED && clk_rise;
  endsequence
  sequence sum_loaded_s;
    reg_q == $past(sum8);
  endsequence
  sequence cell1_reg_s;
    mode_q == PMC_MODE_REGISTERED && cell_cfg_q[3:2] == `PMC_CFG_REG;
  endsequence
  sequence shown_inverted_s;
    io_pins.out[1] == ~$past(reg_q[1]);
  endsequence

  reg_load_a: assert property (@(posedge mclk) disable iff (rst)
    pin_edge_s |=> sum_loaded_s)
    else $error("register did not take the sum");
  reg_show_a: assert property (@(posedge mclk) disable iff (rst)
    pin_edge_s ##1 cell1_reg_s |=> shown_inverted_s)
    else $error("loaded value not shown inverted");

  // Registered-mode combinatorial cell, watched on cell 2; then mode held without a write
  comb_sum_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_REGISTERED && cell_cfg_q[5:4] == `PMC_CFG_COMB)
      |=> io_pins.out[2] == $past(|pterm[2][`PMC_SUM_OE-1:0]))
    else $error("combinatorial cell sum wrong");
  comb_oe_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_REGISTERED && cell_cfg_q[5:4] == `PMC_CFG_COMB)
      |=> io_pins.oe[2] == $past(pterm[2][`PMC_SUM_OE]))
    else $error("combinatorial enable not from term");
  comb_fb_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_REGISTERED && cell_cfg_q[5:4] == `PMC_CFG_COMB)
      |=> fb_array[2] == $past(io_s2_q[2]))
    else $error("combinatorial cell feedback wrong");
  mode_static_a: assert property (@(posedge mclk) disable iff (rst)
    !(cfg_wr && cfg_addr == `PMC_CFG_ADDR_MODE) |=> $stable(mode_q))
    else $error("mode changed without a write");

  // Complex mode
  complex_sum_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_COMPLEX |=> io_pins.out[3] == $past(|pterm[3][`PMC_SUM_OE-1:0]))
    else $error("complex sum wrong");
  inner_fb_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_COMPLEX |=> fb_array[4] == $past(io_s2_q[4]))
    else $error("inner feedback not from pin");
  outer_lo_fb_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_COMPLEX |=> fb_array[`PMC_OUTER_LO] == $past(oe_s_q[1]))
    else $error("outer feedback not oe pin");
  complex_pins_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_COMPLEX |=> clk_array == $past(clk_s_q[1]))
    else $error("clock pin not an array input");

  // Simple mode
  simple_sum_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_SIMPLE && cell_cfg_q[15:14] != `PMC_CFG_IN)
      |=> io_pins.out[7] == $past(sum8[7]) && io_pins.oe[7])
    else $error("simple sum wrong");
  simple_in_off_a: assert property (@(posedge mclk) disable iff (rst)
    (mode_q == PMC_MODE_SIMPLE && cell_cfg_q[1:0] == `PMC_CFG_IN)
      |=> !io_pins.oe[0])
    else $error("simple input cell driven");
  simple_pins_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_SIMPLE
      |=> clk_array == $past(clk_s_q[1]) && oe_array == $past(oe_s_q[1]))
    else $error("pins not plain inputs");
  adjacent_hi_fb_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_SIMPLE |=> fb_array[7] == $past(io_s2_q[6]))
    else $error("upper feedback not from neighbour");
  centre_lo_a: assert property (@(posedge mclk) disable iff (rst)
    mode_q == PMC_MODE_SIMPLE
      |=> !fb_array[`PMC_CENTRE_LO] && io_pins.out[`PMC_CENTRE_LO] == $past(sum8[`PMC_CENTRE_LO]))
    else $error("centre cell not a plain output");

  // Read port returns the register state one cycle after the strobe
  read_state_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_rd && cfg_addr == `PMC_CFG_ADDR_STAT |=> cfg_rdata == {8'h00, $past(reg_q)})
    else $error("state read wrong");

endmodule : pmc_core

// file: shared/pmc_map.svh
// Constants for the macrocell output block: widths, mode codes, reset values.
// Assumes inclusion by the package and the design file only.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_CELLS 8
`define PMC_TERMS 8
`define PMC_SUM_REG 8
`define PMC_SUM_OE 7
`define PMC_OUTER_HI 7
`define PMC_OUTER_LO 0
`define PMC_CENTRE_HI 4
`define PMC_CENTRE_LO 3
`define PMC_REG_RESET 8'h00
`define PMC_MODE_REG 2'h0
`define PMC_MODE_CPX 2'h1
`define PMC_MODE_SMP 2'h3
`define PMC_CFG_REG 2'h0
`define PMC_CFG_COMB 2'h1
`define PMC_CFG_IN 2'h3
`define PMC_CFG_ADDR_MODE 4'h0
`define PMC_CFG_ADDR_CELL 4'h1
`define PMC_CFG_ADDR_STAT 4'h2
`define PMC_CFG_ADDR_PINS 4'h3
`endif

// file: shared/pmc_pkg.sv
// Types for the macrocell output block.
// Assumes pmc_map.svh sits beside it on the include path.
`include "pmc_map.svh"
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_MODE_REGISTERED = `PMC_MODE_REG,
    PMC_MODE_COMPLEX = `PMC_MODE_CPX,
    PMC_MODE_SIMPLE = `PMC_MODE_SMP
  } pmc_mode_type;
  typedef enum logic [1:0] {
    PMC_CELL_REG = `PMC_CFG_REG,
    PMC_CELL_COMB = `PMC_CFG_COMB,
    PMC_CELL_IN = `PMC_CFG_IN
  } pmc_cell_type;
  typedef struct packed {
    logic [`PMC_CELLS-1:0] out;
    logic [`PMC_CELLS-1:0] oe;
  } pmc_pins_type;
endpackage : pmc_pkg

// file: bench/pmc_board.sv
// Board model: pad levels that the block's pin inputs see.
// Assumes the bench sets the board drive; the block wins where it drives.
`timescale 1ns/1ps
module pmc_board
  import pmc_pkg::*;
(
  input wire pmc_pins_type io_pins,
  input wire logic [7:0] drv_val,
  output logic [7:0] io_in
);
  // Released pads follow the board, so input cells read outside levels
  assign io_in = (io_pins.oe & io_pins.out) | (~io_pins.oe & drv_val);
endmodule : pmc_board

// file: bench/tb.sv
// Bench for the macrocell block: bus tasks, pin stimulus, self checks.
// Assumes pmc_board models the pads; settle counts cover the pin sync.
`timescale 1ns/1ps
module tb
  import pmc_pkg::*;
;
  logic mclk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, clk_pin = 0, oe_n_pin = 1;
  logic [3:0] cfg_addr = 0;
  logic [15:0] cfg_wdata = 0, cfg_rdata, rv;
  logic [7:0] pterm [8], io_in, fb_array, drv_val = 0, o0, r, e;
  logic clk_array, oe_array;
  pmc_pins_type io_pins;
  int n_fail = 0, n_compared = 0, cycles = 0;
  always #5 mclk = ~mclk;
  pmc_core dut (.mclk(mclk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .pterm(pterm),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in), .io_pins(io_pins),
    .fb_array(fb_array), .clk_array(clk_array), .oe_array(oe_array));
  pmc_board board (.io_pins(io_pins), .drv_val(drv_val), .io_in(io_in));
  function automatic logic [7:0] sum8();
    for (int i = 0; i < 8; i++)
      sum8[i] = |pterm[i];
  endfunction : sum8
  function automatic logic [7:0] en7();
    for (int i = 0; i < 8; i++)
      en7[i] = pterm[i][7];
  endfunction : en7
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1;
    settle(1);
    cfg_wr <= 0;
    settle(1);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    cfg_addr <= a;
    cfg_rd <= 1;
    settle(1);
    cfg_rd <= 0;
    rv = cfg_rdata;
    settle(1);
  endtask : rd
  // Random terms masked by v; settle covers sync plus register stages
  task automatic setp(input logic [7:0] v, input logic rnd);
    for (int i = 0; i < 8; i++)
      pterm[i] <= rnd ? 8'($urandom) & v : v;
    drv_val <= 8'($urandom);
    settle(8);
  endtask : setp
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Whole run needs under 1500 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'h9828ea7d));
    for (int i = 0; i < 8; i++)
      pterm[i] = 0;
    settle(4);
    rst <= 0;
    settle(1);
    rd(0);
    check("mode", rv, 0);
    rd(1);
    check("cells", rv, 16'hffff);
    rd(2);
    check("state", rv, 0);
    check("oe", io_pins.oe, 0);
    wr(4'h9, 16'hffff);
    rd(4'h9);
    check("unmapped", rv, 0);
    wr(1, 16'h0);
    oe_n_pin <= 0;
    settle(8);
    check("out", io_pins.out, 8'hff);
    check("oe", io_pins.oe, 8'hff);
    oe_n_pin <= 1;
    clk_pin <= 1;
    settle(8);
    check("oe", io_pins.oe, 0);
    check("pins", {clk_array, oe_array}, 0);
    clk_pin <= 0;
    oe_n_pin <= 0;
    for (int i = 0; i < 6; i++)
    begin
      o0 = io_pins.out;
      setp(i[0] ? 8'h80 : 8'hff, 1);
      r = sum8();
      check("hold", io_pins.out, o0);
      clk_pin <= 1;
      settle(8);
      clk_pin <= 0;
      // Cast keeps the inversion to eight bits before widening
      check("out", io_pins.out, 8'(~r));
      rd(2);
      check("state", rv, {8'h0, r});
    end
    wr(1, 16'hfd50);
    setp(8'hff, 1);
    e = en7();
    check("oe", io_pins.oe[7:2], {3'b0, e[4:2]});
    check("fb", fb_array[7:2], io_in[7:2]);
    setp(8'h80, 0);
    o0 = io_pins.out;
    setp(0, 0);
    check("sum7", io_pins.out[4:2], o0[4:2]);
    wr(0, 1);
    wr(1, 16'h5555);
    for (int i = 0; i < 4; i++)
    begin
      clk_pin <= i[0];
      oe_n_pin <= i[1];
      setp(8'hff, 1);
      check("fb", fb_array, {clk_pin, io_in[6:1], oe_n_pin});
      check("oe", io_pins.oe, en7());
    end
    setp(8'h80, 0);
    o0 = io_pins.out;
    setp(0, 0);
    check("sum7", io_pins.out, o0);
    wr(0, 3);
    wr(1, 16'h5fdf);
    clk_pin <= 1;
    setp(8'hff, 1);
    rd(0);
    check("mode", rv, 3);
    check("oe", io_pins.oe, 8'hdc);
    check("fb", {fb_array[7:5], fb_array[2:0]}, {io_in[6:4], io_in[3:1]});
    check("pins", {clk_array, oe_array}, {clk_pin, oe_n_pin});
    setp(8'h80, 0);
    o0 = io_pins.out;
    setp(0, 0);
    check("sum8", (io_pins.out ^ o0) & 8'hdc, 8'hdc);
    print_verdict();
  end
endmodule : tb
